// [verilog/ppm_pkg.sv]
package ppm_pkg;
  // configuration-space placement: capability pointer address, then offsets from capability base
  localparam logic [7:0] CAP_PTR_ADDR = 8'h34;
  localparam logic [7:0] CSR_OFFSET = 8'h04;
  localparam logic [7:0] BSE_OFFSET = 8'h06;
  localparam logic [7:0] DATA_OFFSET = 8'h07;
  // control/status field positions
  localparam int PS_LSB = 0;
  localparam int ALLOW_BIT = 8;
  localparam int SEL_LSB = 9;
  localparam int SCALE_LSB = 13;
  localparam int FLAG_BIT = 15;
  // reset values and reserved-bit mask
  localparam logic [1:0] PS_RESET = 2'h0;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [7:0] BSE_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [15:0] CSR_RESERVED_MASK = 16'h00fc;
  typedef enum logic [1:0] {
    PPM_D0 = 2'h0,
    PPM_D1 = 2'h1,
    PPM_D2 = 2'h2,
    PPM_D3HOT = 2'h3
  } ppm_pstate_t;
endpackage

// [verilog/ppm_wake.sv]
`timescale 1ns/1ps
module ppm_wake (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sticky_mode,
  input wire logic wake_event,
  input wire logic clear_flag,
  input wire logic allow_wr,
  input wire logic allow_wdata,
  output logic wake_event_flag,
  output logic wake_event_allow,
  output logic pme_n_oe
);
  logic flag_r;
  logic flag_nxt;
  logic allow_r;
  logic allow_nxt;
  logic init_r;
  logic init_nxt;

  // next values; set beats clear so a clear in the same cycle loses no event
  always_comb begin
    flag_nxt = flag_r;
    allow_nxt = allow_r;
    init_nxt = 1'b1;
    // [R4] non-sticky clears bits
    if (!init_r && !sticky_mode) begin
      flag_nxt = 1'b0;
      allow_nxt = 1'b0;
    end else begin
      // [R2] write one clears
      if (clear_flag) begin
        flag_nxt = 1'b0;
      end
      // [R1] set regardless of allow
      if (wake_event) begin
        flag_nxt = 1'b1;
      end
      if (allow_wr) begin
        allow_nxt = allow_wdata;
      end
    end
  end

  // sticky bits take no value at reset when aux power keeps them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_r <= 1'b0;
    end else if (ce) begin
      init_r <= init_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      flag_r <= flag_nxt;
      allow_r <= allow_nxt;
    end
  end

  assign wake_event_flag = flag_r;
  assign wake_event_allow = allow_r;
  // [R3] [R13] pme only when both set
  assign pme_n_oe = flag_r & allow_r & init_r;
endmodule

// [verilog/ppm_data.sv]
`timescale 1ns/1ps
module ppm_data (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic data_impl,
  input wire logic [3:0] data_sel,
  input wire logic [7:0] item_value [16],
  input wire logic [1:0] item_scale [16],
  output logic [7:0] data_value,
  output logic [1:0] data_scale
);
  logic [7:0] value_r;
  logic [7:0] value_nxt;
  logic [1:0] scale_r;
  logic [1:0] scale_nxt;

  // [R12] selected item reported
  always_comb begin
    value_nxt = ppm_pkg::DATA_RESET;
    scale_nxt = ppm_pkg::SCALE_NONE;
    if (data_impl) begin
      value_nxt = item_value[data_sel];
      scale_nxt = item_scale[data_sel];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= ppm_pkg::DATA_RESET;
      scale_r <= ppm_pkg::SCALE_NONE;
    end else if (ce) begin
      value_r <= value_nxt;
      scale_r <= scale_nxt;
    end
  end

  assign data_value = value_r;
  // [R5] scale reads zero without data
  assign data_scale = data_impl ? scale_r : ppm_pkg::SCALE_NONE;
endmodule

// [verilog/ppm_ctrl.sv]
`timescale 1ns/1ps
// What this block does
// [R1] wake flag sets on any wake event; without sticky_mode an event in the first ce cycle after reset is dropped
// [R2] writing one clears flag, zero ignored
// [R3] pme driven only while allow set
// [R4] sticky across d3cold, else reset zero
// [R5] two-bit scale field, zero without data
// [R6] four-bit selector, zero without data
// [R7] power state encoding d0 to d3hot
// [R8] unsupported state write is discarded
// [R9] software writes reserved bits as zero
// [R10] control word at capability base plus four
// [R11] bridge byte at plus six reads zero
// [R12] data byte reports selected scaled item
// [R13] pme asserted when flag and allow, once init_r sets at the first ce edge after reset
module ppm_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sticky_mode,
  input wire logic d1_support,
  input wire logic d2_support,
  input wire logic data_impl,
  input wire logic [7:0] cap_base,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_hit,
  input wire logic wake_event,
  input wire logic [7:0] item_value [16],
  input wire logic [1:0] item_scale [16],
  output logic [1:0] power_state_field,
  output logic pme_n_o,
  output logic pme_n_oe
);
  logic [1:0] ps_r;
  logic [1:0] ps_nxt;
  logic [3:0] sel_r;
  logic [3:0] sel_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wake_event_flag;
  logic wake_event_allow;
  logic [1:0] data_scale;
  logic [7:0] data_value;
  logic [7:0] csr_addr;
  logic dword_hit;
  logic lo_wr;
  logic hi_wr;
  logic clear_flag;
  logic allow_wr;
  logic [15:0] csr_word;

  // checks whether a requested state is implemented
  function automatic logic state_ok(input logic [1:0] s, input logic d1,
                                    input logic d2);
    case (s)
      ppm_pkg::PPM_D1: state_ok = d1;
      ppm_pkg::PPM_D2: state_ok = d2;
      default: state_ok = 1'b1;
    endcase
  endfunction

  // [R10] decode word at base plus four
  assign csr_addr = cap_base + ppm_pkg::CSR_OFFSET;
  assign dword_hit = (cfg_addr[7:2] == csr_addr[7:2]);
  assign cfg_hit = dword_hit & (cfg_rd | cfg_wr);
  assign lo_wr = cfg_wr & dword_hit & cfg_be[0];
  assign hi_wr = cfg_wr & dword_hit & cfg_be[1];
  // [R2] write one clears flag
  assign clear_flag = hi_wr & cfg_wdata[ppm_pkg::FLAG_BIT];
  assign allow_wr = hi_wr;

  ppm_wake u_wake (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .sticky_mode(sticky_mode),
    .wake_event(wake_event),
    .clear_flag(clear_flag),
    .allow_wr(allow_wr),
    .allow_wdata(cfg_wdata[ppm_pkg::ALLOW_BIT]),
    .wake_event_flag(wake_event_flag),
    .wake_event_allow(wake_event_allow),
    .pme_n_oe(pme_n_oe)
  );

  ppm_data u_data (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .data_impl(data_impl),
    .data_sel(sel_r),
    .item_value(item_value),
    .item_scale(item_scale),
    .data_value(data_value),
    .data_scale(data_scale)
  );

  // power state and selector updates
  always_comb begin
    ps_nxt = ps_r;
    sel_nxt = sel_r;
    // [R7] [R8] unsupported state dropped
    if (lo_wr && state_ok(cfg_wdata[1:0], d1_support, d2_support)) begin
      ps_nxt = cfg_wdata[1:0];
    end
    // [R6] selector writable only with data
    if (hi_wr && data_impl) begin
      sel_nxt = cfg_wdata[12:9];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ps_r <= ppm_pkg::PS_RESET;
      sel_r <= ppm_pkg::SEL_RESET;
    end else if (ce) begin
      ps_r <= ps_nxt;
      sel_r <= sel_nxt;
    end
  end

  // reserved bits 7..2 always read zero
  always_comb begin
    csr_word = '0;
    csr_word[ppm_pkg::FLAG_BIT] = wake_event_flag;
    // [R5] scale read-only
    csr_word[14:13] = data_scale;
    csr_word[12:9] = data_impl ? sel_r : ppm_pkg::SEL_RESET;
    csr_word[ppm_pkg::ALLOW_BIT] = wake_event_allow;
    csr_word[1:0] = ps_r;
  end

  // read data registered one cycle after the read strobe
  always_comb begin
    rdata_nxt = rdata_r;
    if (cfg_rd) begin
      rdata_nxt = '0;
      if (dword_hit) begin
        // [R11] bridge byte reads zero
        rdata_nxt = {data_value, ppm_pkg::BSE_RESET, csr_word};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cfg_rdata = rdata_r;
  assign power_state_field = ps_r;
  // open-drain: low level only, enable carries the request
  assign pme_n_o = 1'b0;
endmodule

// [test/ppm_ctrl_asserts.sv]
`timescale 1ns/1ps
module ppm_ctrl_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic data_impl,
  input wire logic [7:0] cap_base,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_hit,
  input wire logic wake_event,
  input wire logic [1:0] power_state_field,
  input wire logic pme_n_oe
);
  logic [7:0] csr_a;
  logic rd_hit;
  logic wr_hit;
  // qualified accesses to the control dword
  assign csr_a = cap_base + ppm_pkg::CSR_OFFSET;
  assign rd_hit = ce && cfg_rd && cfg_hit;
  assign wr_hit = ce && cfg_wr && cfg_hit;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_hit_decode: assert property (
    ce && (cfg_rd || cfg_wr) |-> cfg_hit == (cfg_addr[7:2] == csr_a[7:2]))
    else $error("hit decode wrong");
  a_miss_zero: assert property (
    ce && cfg_rd && !cfg_hit |=> cfg_rdata == 32'h0)
    else $error("missed read not zero");
  a_ps_read: assert property (
    rd_hit |=> cfg_rdata[1:0] == $past(power_state_field))
    else $error("power state readback wrong");
  a_bridge_zero: assert property (
    rd_hit |=> cfg_rdata[23:16] == 8'h00 && cfg_rdata[7:2] == 6'h00)
    else $error("bridge byte or reserved bits set");
  a_no_data: assert property (
    rd_hit && !data_impl |=>
      cfg_rdata[31:24] == 8'h0 && cfg_rdata[14:9] == 6'h0)
    else $error("data fields live without data byte");
  a_pme_match: assert property (
    rd_hit |=> (cfg_rdata[15] && cfg_rdata[8]) == $past(pme_n_oe))
    else $error("wake request disagrees with flag and allow");
  a_clear_stops: assert property (
    wr_hit && cfg_be[1] && cfg_wdata[15] && !wake_event |=> !pme_n_oe)
    else $error("wake request kept after clear");
  a_allow_gate: assert property (
    wr_hit && cfg_be[1] && !cfg_wdata[8] |=> !pme_n_oe)
    else $error("wake request driven while not allowed");
endmodule
bind ppm_ctrl ppm_ctrl_chk u_ppm_ctrl_chk (.*);

// [test/ppm_host.sv]
`timescale 1ns/1ps
module ppm_host (
  input wire logic clk_sys,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  // idle bus at time zero
  initial begin
    {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  // one access held over one rising edge; data scrambled after release
  // caller keeps reserved bits zero, clears by writing one
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys);
    {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {!w, w, a, be, d};
    @(negedge clk_sys);
    {cfg_rd, cfg_wr, cfg_wdata} = {2'b00, ~d};
  endtask
endmodule

// [test/ppm_ctrl_tb.sv]
`timescale 1ns/1ps
module ppm_ctrl_tb;
  logic clk_sys, rst_n, sticky_mode, d1_support, data_impl, wake_event;
  logic cfg_rd, cfg_wr, cfg_hit, pme_n_oe;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [1:0] power_state_field;
  logic [7:0] item_value [16];
  logic [1:0] item_scale [16];
  int err_count = 0;
  int n_tests = 0;
  localparam logic [7:0] CAP = 8'h40;
  localparam logic [7:0] CSR = CAP + ppm_pkg::CSR_OFFSET;
  // control word written, then whole dword expected back
  logic [47:0] rows [5] = '{48'h0003_10000003, 48'h0001_10000001,
    48'h0002_10000002, 48'h0a00_15002a00, 48'h0100_10000100};
  ppm_ctrl u_ppm_ctrl (.*, .ce(1'b1), .cap_base(CAP),
    .d2_support(d1_support), .pme_n_o());
  ppm_host u_ppm_host (.*);
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d, input logic [3:0] be);
    u_ppm_host.acc(1'b1, CSR, be, {16'h0, d});
  endtask
  task automatic rd(input logic [7:0] a);
    u_ppm_host.acc(1'b0, a, 4'hf, 32'h0);
  endtask
  task automatic pulse_wake();
    @(negedge clk_sys) wake_event = 1'b1;
    @(negedge clk_sys) wake_event = 1'b0;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // watchdog at 5000 cycles, far beyond the fewer than one hundred cycles needed
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
  initial begin
    {rst_n, sticky_mode, d1_support, data_impl, wake_event} = 5'b00110;
    for (int i = 0; i < 16; i++) begin
      item_value[i] = 8'h10 + 8'(i);
      item_scale[i] = 2'(i);
    end
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(CSR);
    chk("reset", 32'h10000000, cfg_rdata);
    foreach (rows[i]) begin
      wr(rows[i][47:32], 4'h3);
      repeat (2) @(negedge clk_sys);
      rd(CSR);
      chk("row", rows[i][31:0], cfg_rdata);
    end
    $display("table done");
    // optional states off: writes dropped
    d1_support = 1'b0;
    wr(16'h0003, 4'h1);
    for (int s = 1; s < 3; s++) begin
      wr(16'(s), 4'h1);
      rd(CSR);
      chk("ps", 32'h3, {30'h0, cfg_rdata[1:0]});
      chk("ps pin", 32'h3, {30'h0, power_state_field});
    end
    rd(CSR + 8'h04);
    chk("miss", 32'h0, cfg_rdata);
    wr(16'h0000, 4'h2);
    pulse_wake();
    rd(CSR);
    chk("flag", 32'h1, {31'h0, cfg_rdata[15]});
    chk("pme off", 32'h0, {31'h0, pme_n_oe});
    wr(16'h0100, 4'h2);
    @(negedge clk_sys);
    chk("pme on", 32'h1, {31'h0, pme_n_oe});
    wr(16'h0100, 4'h2);
    chk("zero kept", 32'h1, {31'h0, pme_n_oe});
    wr(16'h8100, 4'h2);
    @(negedge clk_sys);
    chk("cleared", 32'h0, {31'h0, pme_n_oe});
    data_impl = 1'b0;
    wr(16'h0a00, 4'h2);
    repeat (2) @(negedge clk_sys);
    rd(CSR);
    chk("no data", 32'h0,
      {cfg_rdata[31:24], 10'h0, cfg_rdata[14:9], 8'h0});
    // sticky bits survive a reset
    sticky_mode = 1'b1;
    wr(16'h0100, 4'h2);
    pulse_wake();
    rst_n = 1'b0;
    @(negedge clk_sys) rst_n = 1'b1;
    rd(CSR);
    chk("sticky", 32'h8100, {16'h0, cfg_rdata[15:0] & 16'h8103});
    // without sticky support a reset drops flag and allow
    sticky_mode = 1'b0;
    @(negedge clk_sys) rst_n = 1'b0;
    @(negedge clk_sys) rst_n = 1'b1;
    rd(CSR);
    chk("plain reset", 32'h0, {16'h0, cfg_rdata[15:0] & 16'h8103});
    chk("pme reset", 32'h0, {31'h0, pme_n_oe});
    $display("hand tests done");
    stop_test();
  end
endmodule
